// file: hw/spc_pkg.sv
`default_nettype none
package spc_pkg;
  localparam int ADDR_W = 8;
  localparam int LEVELS = 3;

  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SELS    = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DESC    = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ARCH    = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_RESULT  = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CUR_SS  = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_CUR_SP  = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_LVL_SEL = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_LVL_PTR = 8'h24;
  localparam logic [ADDR_W-1:0] LVL_STRIDE   = 8'h08;

  localparam logic [7:0]  EXC_GP     = 8'h0d;
  localparam logic [7:0]  EXC_STACK  = 8'h0c;
  localparam logic [7:0]  EXC_NP     = 8'h0b;
  localparam logic [31:0] PUSH_W32   = 32'h4;
  localparam logic [31:0] PUSH_W16   = 32'h2;
  localparam logic [7:0]  COUNT_STEP = 8'h1;
  localparam logic [4:0]  COPY_STEP  = 5'h1;

  typedef enum logic [2:0] {
    OP_LOAD_DATA, OP_LOAD_STACK, OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN_OP, OP_INT, OP_ADJUST_PRIVILEGE_OP
  } spc_op_e;

  typedef enum logic [3:0] {
    DT_DATA_RO, DT_DATA_RW, DT_CODE_XO, DT_CODE_XR,
    DT_CALL_GATE, DT_INT_GATE, DT_TRAP_GATE, DT_TASK_GATE, DT_TSS
  } spc_dtype_e;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_CHECK   = 3'b001,
    ST_LOADCS  = 3'b011,
    ST_PUSHSS  = 3'b010,
    ST_PUSHSP  = 3'b110,
    ST_COPY    = 3'b111,
    ST_PUSHRET = 3'b101,
    ST_DONE    = 3'b100
  } spc_state_e;

  typedef struct packed {
    logic        start;
    logic [27:0] rsvd;
    spc_op_e     op;
  } spc_ctrl_s;

  typedef struct packed {
    logic [12:0] rsvd;
    logic [4:0]  wordCount;
    logic        fromIdt;
    logic        legacy;
    logic        tgtPresent;
    logic        tgtConf;
    logic [1:0]  tgtDpl;
    logic        present;
    logic [1:0]  descriptor_privilege_field;
    logic        conf;
    spc_dtype_e  dtype;
  } spc_desc_s;

  typedef struct packed {
    logic [27:0] rsvd;
    logic        ifl;
    logic        nt;
    logic [1:0]  current_privilege_level;
  } spc_arch_s;

  typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] pushCount;
    logic [7:0] vector;
    logic [1:0] rsvd2;
    logic       zf;
    logic       stackSw;
    logic       taskSw;
    logic       fault;
    logic       done;
    logic       busy;
  } spc_status_s;

  typedef struct packed {
    logic       fault;
    logic [7:0] vector;
    logic       taskSw;
    logic       stackSw;
    logic       outer;
    logic       clrIf;
    logic [1:0] newCpl;
  } spc_verdict_s;

  typedef struct packed {
    spc_state_e             fsm;
    spc_ctrl_s              ctrl;
    logic [31:0]            sels;
    spc_desc_s              desc;
    spc_arch_s              arch;
    spc_status_s            status;
    logic [15:0]            result;
    logic [15:0]            curSs;
    logic [31:0]            curSp;
    logic [15:0]            oldSs;
    logic [31:0]            oldSp;
    logic [LEVELS-1:0][15:0] lvlSel;
    logic [LEVELS-1:0][31:0] lvlPtr;
    logic [4:0]             copyLeft;
    spc_verdict_s           verdict;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
  } spc_st_s;
endpackage : spc_pkg
`default_nettype wire

// file: hw/spc_segment_privilege_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spc_segment_privilege_checker (
  input  wire logic                       core_clk, // 50 MHz core clock
  input  wire logic                       rstn,     // async reset, active low
  input  wire logic                       psel,     // apb select
  input  wire logic                       penable,  // apb access phase
  input  wire logic                       pwrite,   // apb direction
  input  wire logic [spc_pkg::ADDR_W-1:0] paddr,    // apb byte address
  input  wire logic [31:0]                pwdata,   // apb write data
  output logic      [31:0]                prdata,   // apb read data
  output logic                            pready,   // apb ready
  output logic                            pslverr   // apb error
);
  import spc_pkg::*;

  spc_st_s      stReg;
  spc_st_s      stNext;
  spc_verdict_s v;
  logic [LEVELS-1:0] lvlSelHit;
  logic [LEVELS-1:0] lvlPtrHit;

  // one address pair per inner privilege level stack, levels 0 to 2
  genvar gi;
  generate
    for (gi = 0; gi < LEVELS; gi++) begin : g_lvl
      assign lvlSelHit[gi] = (paddr == ADDR_W'(ADDR_LVL_SEL + gi * LVL_STRIDE));
      assign lvlPtrHit[gi] = (paddr == ADDR_W'(ADDR_LVL_PTR + gi * LVL_STRIDE));
    end
  endgenerate

  // verdict of the pending request
  logic [1:0] requested_privilege_field;
  logic [1:0] current_privilege_level;
  logic [1:0] effective_privilege_level;
  logic       isCode;
  logic       isTask;
  logic       presentOk;
  spc_desc_s  d;
  always_comb begin
    d         = stReg.desc;
    requested_privilege_field       = stReg.sels[1:0];
    current_privilege_level       = stReg.arch.current_privilege_level;
    effective_privilege_level       = (requested_privilege_field > current_privilege_level) ? requested_privilege_field : current_privilege_level;
    isCode    = (d.dtype == DT_CODE_XO || d.dtype == DT_CODE_XR) && !d.fromIdt;
    isTask    = (d.dtype == DT_TASK_GATE || d.dtype == DT_TSS) && !d.fromIdt;
    presentOk = d.present;
    v         = '0;
    v.newCpl  = current_privilege_level;
    v.vector  = EXC_GP;
    unique case (stReg.ctrl.op)
      OP_LOAD_DATA: begin
        if (!(d.dtype == DT_DATA_RO || d.dtype == DT_DATA_RW || d.dtype == DT_CODE_XR)) begin
          v.fault = 1'b1;
        // conforming readable code skips level check
        end else if (!(d.dtype == DT_CODE_XR && d.conf) && effective_privilege_level > d.descriptor_privilege_field) begin
          v.fault = 1'b1;
        end
      end
      OP_LOAD_STACK: begin
        // writable data at current level only
        if (d.dtype != DT_DATA_RW || d.descriptor_privilege_field != current_privilege_level || requested_privilege_field != current_privilege_level) begin
          v.fault = 1'b1;
        end
      end
      OP_JMP, OP_CALL: begin
        // direct code targets never change level
        if (isCode) begin
          v.fault = d.conf ? (d.descriptor_privilege_field > current_privilege_level) : (d.descriptor_privilege_field != current_privilege_level);
        end else if (isTask) begin
          v.fault  = d.descriptor_privilege_field < effective_privilege_level;
          v.taskSw = 1'b1;
        end else if (d.dtype == DT_CALL_GATE && !d.fromIdt && stReg.ctrl.op == OP_CALL) begin
          v.fault     = (effective_privilege_level > d.descriptor_privilege_field) || (d.tgtDpl > current_privilege_level);
          v.stackSw   = !d.tgtConf && d.tgtDpl < current_privilege_level;
          v.newCpl    = v.stackSw ? d.tgtDpl : current_privilege_level;
          presentOk   = d.present && d.tgtPresent;
        end else begin
          v.fault = 1'b1;
        end
      end
      OP_INT: begin
        if (d.fromIdt && (d.dtype == DT_INT_GATE || d.dtype == DT_TRAP_GATE)) begin
          // same checks as a gated call
          v.fault     = (effective_privilege_level > d.descriptor_privilege_field) || (d.tgtDpl > current_privilege_level);
          v.stackSw   = !d.tgtConf && d.tgtDpl < current_privilege_level;
          v.newCpl    = v.stackSw ? d.tgtDpl : current_privilege_level;
          v.clrIf     = d.dtype == DT_INT_GATE;
          presentOk   = d.present && d.tgtPresent;
        // task gate in the interrupt table
        end else if (d.fromIdt && d.dtype == DT_TASK_GATE) begin
          v.fault  = d.descriptor_privilege_field < effective_privilege_level;
          v.taskSw = 1'b1;
        end else begin
          v.fault = 1'b1;
        end
      end
      OP_RET, OP_INTERRUPT_RETURN_OP: begin
        // nested flag set: interrupt_return_op is a task switch back
        if (stReg.ctrl.op == OP_INTERRUPT_RETURN_OP && stReg.arch.nt) begin
          v.fault  = !(d.dtype == DT_TASK_GATE && !d.fromIdt);
          v.taskSw = 1'b1;
        end else if (isCode) begin
          v.fault  = (requested_privilege_field < current_privilege_level) || (d.conf ? (d.descriptor_privilege_field > requested_privilege_field) : (d.descriptor_privilege_field != requested_privilege_field));
          v.outer  = requested_privilege_field > current_privilege_level;
          v.newCpl = requested_privilege_field;
        end else begin
          v.fault = 1'b1;
        end
      end
      OP_ADJUST_PRIVILEGE_OP: begin
        presentOk = 1'b1;
      end
    endcase
    // absence is reported only once type and level pass
    if (!v.fault && !presentOk) begin
      v.fault  = 1'b1;
      v.vector = (stReg.ctrl.op == OP_LOAD_STACK) ? EXC_STACK : EXC_NP;
    end
    if (!v.fault) begin
      v.vector = '0;
    end
  end

  // next state: apb slave plus sequencer
  logic        access;
  logic        doWrite;
  logic        hit;
  logic [31:0] rd;
  logic [31:0] pushW;
  logic [1:0]  argRpl;
  spc_status_s stat;
  always_comb begin
    stNext         = stReg;
    stNext.pready  = 1'b0;
    stNext.pslverr = 1'b0;
    access         = psel && penable && !stReg.pready;
    doWrite        = psel && penable && stReg.pready && pwrite && !stReg.pslverr;
    pushW          = stReg.desc.legacy ? PUSH_W16 : PUSH_W32;
    argRpl         = stReg.sels[17:16];
    stat           = stReg.status;
    stat.busy      = stReg.fsm != ST_IDLE;
    hit            = 1'b1;
    rd             = '0;
    case (paddr)
      ADDR_CTRL:   rd = stReg.ctrl;
      ADDR_SELS:   rd = stReg.sels;
      ADDR_DESC:   rd = stReg.desc;
      ADDR_ARCH:   rd = stReg.arch;
      ADDR_STATUS: rd = stat;
      ADDR_RESULT: rd = {16'h0000, stReg.result};
      ADDR_CUR_SS: rd = {16'h0000, stReg.curSs};
      ADDR_CUR_SP: rd = stReg.curSp;
      default:     hit = 1'b0;
    endcase
    for (int i = 0; i < LEVELS; i++) begin
      if (lvlSelHit[i]) begin
        hit = 1'b1;
        rd  = {16'h0000, stReg.lvlSel[i]};
      end
      if (lvlPtrHit[i]) begin
        hit = 1'b1;
        rd  = stReg.lvlPtr[i];
      end
    end
    // one wait state; a busy sequencer refuses writes
    if (access) begin
      stNext.pready  = 1'b1;
      stNext.prdata  = pwrite ? '0 : rd;
      stNext.pslverr = !hit || (pwrite && stat.busy);
    end
    if (doWrite) begin
      case (paddr)
        ADDR_CTRL: begin
          stNext.ctrl       = pwdata;
          stNext.ctrl.rsvd  = '0;
          stNext.ctrl.start = 1'b0;
          if (pwdata[31]) begin
            stNext.fsm    = ST_CHECK;
            stNext.status = '0;
          end
        end
        ADDR_SELS: stNext.sels = pwdata;
        ADDR_DESC: begin
          stNext.desc      = pwdata;
          stNext.desc.rsvd = '0;
        end
        ADDR_ARCH: begin
          stNext.arch      = pwdata;
          stNext.arch.rsvd = '0;
        end
        ADDR_CUR_SS: stNext.curSs = pwdata[15:0];
        ADDR_CUR_SP: stNext.curSp = pwdata;
        default: ;
      endcase
      for (int i = 0; i < LEVELS; i++) begin
        if (lvlSelHit[i]) begin
          stNext.lvlSel[i] = pwdata[15:0];
        end
        if (lvlPtrHit[i]) begin
          stNext.lvlPtr[i] = pwdata;
        end
      end
    end
    unique case (stReg.fsm)
      ST_IDLE: ;
      ST_CHECK: begin
        stNext.verdict        = v;
        stNext.status.fault   = v.fault;
        stNext.status.vector  = v.vector;
        stNext.status.taskSw  = v.taskSw;
        stNext.status.stackSw = v.stackSw;
        stNext.fsm            = ST_DONE;
        if (v.fault) begin
          stNext.fsm = ST_DONE;
        end else if (stReg.ctrl.op == OP_ADJUST_PRIVILEGE_OP) begin
          // raise requested bits, flag the change
          stNext.result    = {stReg.sels[15:2], (argRpl > requested_privilege_field) ? argRpl : requested_privilege_field};
          stNext.status.zf = argRpl > requested_privilege_field;
        end else if (v.stackSw) begin
          stNext.fsm       = ST_LOADCS;
          stNext.copyLeft  = (stReg.ctrl.op == OP_INT) ? '0 : stReg.desc.wordCount;
        end else begin
          stNext.arch.current_privilege_level = v.newCpl;
          if (v.clrIf) begin
            stNext.arch.ifl = 1'b0;
          end
          if (v.outer) begin
            stNext.curSs = stReg.oldSs;
            stNext.curSp = stReg.oldSp;
          end
        end
      end
      ST_LOADCS: begin
        // code load first, then the level changes through the gate
        stNext.arch.current_privilege_level = stReg.verdict.newCpl;
        // interrupts off behind an interrupt gate
        if (stReg.verdict.clrIf) begin
          stNext.arch.ifl = 1'b0;
        end
        // inner stack from the per-level slots, old one kept
        stNext.oldSs = stReg.curSs;
        stNext.oldSp = stReg.curSp;
        stNext.curSs = stReg.lvlSel[stReg.verdict.newCpl];
        stNext.curSp = stReg.lvlPtr[stReg.verdict.newCpl];
        stNext.fsm   = ST_PUSHSS;
      end
      ST_PUSHSS: begin
        // old selector, widened to the push size
        stNext.curSp            = stReg.curSp - pushW;
        stNext.status.pushCount = stReg.status.pushCount + COUNT_STEP;
        stNext.fsm              = ST_PUSHSP;
      end
      ST_PUSHSP: begin
        // previous pointer onto the new stack
        stNext.curSp            = stReg.curSp - pushW;
        stNext.status.pushCount = stReg.status.pushCount + COUNT_STEP;
        stNext.fsm              = (stReg.copyLeft != '0) ? ST_COPY : ST_PUSHRET;
      end
      ST_COPY: begin
        stNext.curSp            = stReg.curSp - pushW;
        stNext.status.pushCount = stReg.status.pushCount + COUNT_STEP;
        stNext.copyLeft         = stReg.copyLeft - COPY_STEP;
        if (stReg.copyLeft == COPY_STEP) begin
          stNext.fsm = ST_PUSHRET;
        end
      end
      ST_PUSHRET: begin
        // return selector and pointer, two items
        stNext.curSp            = stReg.curSp - (pushW + pushW);
        stNext.status.pushCount = stReg.status.pushCount + COUNT_STEP + COUNT_STEP;
        stNext.fsm              = ST_DONE;
      end
      ST_DONE: begin
        stNext.status.done = 1'b1;
        stNext.fsm         = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

  assign prdata  = stReg.prdata;
  assign pready  = stReg.pready;
  assign pslverr = stReg.pslverr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_inwardStart;
    stReg.fsm == ST_LOADCS;
  endsequence
  sequence s_stackPushes;
    stReg.fsm == ST_PUSHSS ##1 stReg.fsm == ST_PUSHSP;
  endsequence

  a_fault_keeps_arch: assert property (stReg.fsm == ST_CHECK && v.fault |=>
    stReg.arch == $past(stReg.arch) && stReg.curSp == $past(stReg.curSp) && stReg.fsm == ST_DONE)
    else $error("fault changed state");
  a_data_type_fault: assert property (stReg.fsm == ST_CHECK && stReg.ctrl.op == OP_LOAD_DATA
    && stReg.desc.dtype == DT_CODE_XO |=> stReg.status.fault && stReg.status.vector == EXC_GP)
    else $error("execute-only data load accepted");
  a_stack_level_fault: assert property (stReg.fsm == ST_CHECK && stReg.ctrl.op == OP_LOAD_STACK
    && stReg.desc.descriptor_privilege_field != stReg.arch.current_privilege_level |=> stReg.status.fault && stReg.status.vector == EXC_GP)
    else $error("stack level mismatch accepted");
  a_absent_stack_vec: assert property (stReg.fsm == ST_CHECK && stReg.ctrl.op == OP_LOAD_STACK
    && stReg.desc.dtype == DT_DATA_RW && stReg.desc.descriptor_privilege_field == stReg.arch.current_privilege_level
    && stReg.sels[1:0] == stReg.arch.current_privilege_level && !stReg.desc.present
    |=> stReg.status.fault && stReg.status.vector == EXC_STACK)
    else $error("absent stack not reported as stack fault");
  a_jmp_gate_fault: assert property (stReg.fsm == ST_CHECK && stReg.ctrl.op == OP_JMP
    && stReg.desc.dtype == DT_CALL_GATE |=> stReg.status.fault && stReg.status.vector == EXC_GP)
    else $error("jump through call gate accepted");
  a_push_order_seq: assert property (s_inwardStart |=> s_stackPushes)
    else $error("stack push order broken");
  a_new_stack_load: assert property (s_inwardStart |=>
    stReg.curSs == stReg.lvlSel[stReg.verdict.newCpl] && stReg.oldSp == $past(stReg.curSp))
    else $error("inner stack not loaded");
  a_push_item_width: assert property (stReg.fsm == ST_PUSHSS |=>
    stReg.curSp == $past(stReg.curSp) - (stReg.desc.legacy ? PUSH_W16 : PUSH_W32))
    else $error("push width wrong");
  a_int_gate_if: assert property (stReg.fsm == ST_CHECK && stReg.ctrl.op == OP_INT && !v.fault
    && stReg.desc.dtype == DT_INT_GATE |-> ##[1:2] !stReg.arch.ifl)
    else $error("interrupt gate left interrupts on");
  a_adjust_privilege_op_raise: assert property (stReg.fsm == ST_CHECK && stReg.ctrl.op == OP_ADJUST_PRIVILEGE_OP |=>
    stReg.result[1:0] >= $past(stReg.sels[1:0]) && stReg.status.zf == ($past(stReg.sels[17:16]) >
    $past(stReg.sels[1:0]))) else $error("adjust result wrong");
  a_outer_restore: assert property (stReg.fsm == ST_CHECK && !v.fault && v.outer |=>
    stReg.curSp == $past(stReg.oldSp) && stReg.arch.current_privilege_level == $past(stReg.sels[1:0]))
    else $error("outer stack not restored");
endmodule : spc_segment_privilege_checker
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spc_pkg::*;
  logic              core_clk;
  logic              rstn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [31:0]       rd;
  logic              err;
  spc_status_s       st;
  spc_desc_s         g;
  logic [1:0]        x;
  logic [1:0]        y;
  logic [1:0]        z;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                cycles = 0;

  spc_segment_privilege_checker dut_u (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // hang guard: well under two thousand cycles are expected, ceiling leaves ample margin
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // psel stays high between transfers; every call still drives it high again in the setup phase
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
  endtask : apb

  function automatic spc_desc_s mk(spc_dtype_e t, logic [1:0] l, logic cf, logic p);
    spc_desc_s d;
    d = '0;
    d.dtype = t;
    d.descriptor_privilege_field = l;
    d.conf = cf;
    d.present = p;
    d.tgtPresent = 1'b1;
    return d;
  endfunction : mk

  function automatic logic [1:0] mx(logic [1:0] a, logic [1:0] b);
    return (a > b) ? a : b;
  endfunction : mx

  function automatic logic [7:0] dataExp(logic [1:0] c, logic [1:0] r, logic [1:0] d, logic p);
    if (mx(c, r) > d) return EXC_GP;
    return p ? 8'h00 : EXC_NP;
  endfunction : dataExp

  task automatic tryOp(input spc_op_e op, input logic [1:0] current_privilege_level, input logic nt, input logic [31:0] sels,
                       input spc_desc_s d, input logic [7:0] vec);
    spc_ctrl_s c;
    spc_arch_s a;
    a = '0;
    a.current_privilege_level = current_privilege_level;
    a.nt = nt;
    a.ifl = 1'b1;
    c = '0;
    c.start = 1'b1;
    c.op = op;
    apb(1'b1, ADDR_ARCH, a);
    apb(1'b1, ADDR_SELS, sels);
    apb(1'b1, ADDR_DESC, d);
    apb(1'b1, ADDR_CTRL, c);
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
    end while (rd[1] !== 1'b1);
    st = rd;
    chk("fault", {31'h0, vec != 8'h00}, {31'h0, st.fault});
    chk("vector", {24'h0, vec}, {24'h0, st.vector});
  endtask : tryOp

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(32'h610e));
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // a write landing while the sequencer runs must be refused and dropped
    apb(1'b1, ADDR_CTRL, {1'b1, 28'h0, OP_ADJUST_PRIVILEGE_OP});
    apb(1'b1, ADDR_ARCH, 32'h3);
    chk("busy write error", 32'h1, {31'h0, err});
    apb(1'b0, ADDR_ARCH, 32'h0);
    chk("busy write dropped", 32'h0, rd);
    tryOp(OP_LOAD_DATA, 2'd1, 1'b0, 32'h3, mk(DT_DATA_RW, 2'd2, 1'b0, 1'b1), EXC_GP);
    tryOp(OP_LOAD_DATA, 2'd0, 1'b0, 32'h0, mk(DT_CODE_XO, 2'd3, 1'b0, 1'b1), EXC_GP);
    tryOp(OP_LOAD_DATA, 2'd3, 1'b0, 32'h3, mk(DT_CODE_XR, 2'd0, 1'b1, 1'b1), 8'h00);
    tryOp(OP_LOAD_DATA, 2'd0, 1'b0, 32'h0, mk(DT_DATA_RO, 2'd3, 1'b0, 1'b0), EXC_NP);
    tryOp(OP_LOAD_STACK, 2'd1, 1'b0, 32'h1, mk(DT_DATA_RW, 2'd1, 1'b0, 1'b1), 8'h00);
    tryOp(OP_LOAD_STACK, 2'd1, 1'b0, 32'h1, mk(DT_DATA_RW, 2'd1, 1'b0, 1'b0), EXC_STACK);
    tryOp(OP_LOAD_STACK, 2'd1, 1'b0, 32'h1, mk(DT_DATA_RO, 2'd1, 1'b0, 1'b1), EXC_GP);
    tryOp(OP_LOAD_STACK, 2'd1, 1'b0, 32'h0, mk(DT_DATA_RW, 2'd1, 1'b0, 1'b1), EXC_GP);
    tryOp(OP_LOAD_STACK, 2'd1, 1'b0, 32'h1, mk(DT_DATA_RW, 2'd2, 1'b0, 1'b1), EXC_GP);
    tryOp(OP_JMP, 2'd3, 1'b0, 32'h3, mk(DT_CALL_GATE, 2'd3, 1'b0, 1'b1), EXC_GP);
    tryOp(OP_JMP, 2'd3, 1'b0, 32'h3, mk(DT_CODE_XO, 2'd1, 1'b1, 1'b1), 8'h00);
    tryOp(OP_JMP, 2'd3, 1'b0, 32'h3, mk(DT_CODE_XO, 2'd1, 1'b0, 1'b1), EXC_GP);
    tryOp(OP_JMP, 2'd1, 1'b0, 32'h1, mk(DT_CODE_XO, 2'd3, 1'b1, 1'b1), EXC_GP);
    tryOp(OP_CALL, 2'd3, 1'b0, 32'h3, mk(DT_CODE_XO, 2'd0, 1'b0, 1'b1), EXC_GP);
    tryOp(OP_RET, 2'd3, 1'b0, 32'h0, mk(DT_CODE_XO, 2'd0, 1'b0, 1'b1), EXC_GP);
    tryOp(OP_INTERRUPT_RETURN_OP, 2'd2, 1'b1, 32'h2, mk(DT_TASK_GATE, 2'd2, 1'b0, 1'b1), 8'h00);
    chk("task switch", 32'h1, {31'h0, st.taskSw});
    tryOp(OP_INTERRUPT_RETURN_OP, 2'd2, 1'b0, 32'h2, mk(DT_CODE_XO, 2'd2, 1'b0, 1'b1), 8'h00);
    chk("task switch", 32'h0, {31'h0, st.taskSw});
    tryOp(OP_JMP, 2'd3, 1'b0, 32'h3, mk(DT_TSS, 2'd3, 1'b0, 1'b1), 8'h00);
    chk("task switch", 32'h1, {31'h0, st.taskSw});
    tryOp(OP_CALL, 2'd3, 1'b0, 32'h3, mk(DT_TSS, 2'd0, 1'b0, 1'b1), EXC_GP);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ADDR_CUR_SS, 32'h2b);
      apb(1'b1, ADDR_CUR_SP, 32'h8000);
      apb(1'b1, ADDR_LVL_SEL, 32'h10);
      apb(1'b1, ADDR_LVL_PTR, 32'h1000);
      g = mk(DT_CALL_GATE, 2'd3, 1'b0, 1'b1);
      g.wordCount = 5'd2;
      g.legacy = k[0];
      tryOp(OP_CALL, 2'd3, 1'b0, 32'h3, g, 8'h00);
      chk("pushes", 32'd6, {24'h0, st.pushCount});
      apb(1'b0, ADDR_CUR_SP, 32'h0);
      chk("new sp", k ? 32'h0ff4 : 32'h0fe8, rd);
      apb(1'b0, ADDR_CUR_SS, 32'h0);
      chk("new ss", 32'h10, rd);
      apb(1'b0, ADDR_ARCH, 32'h0);
      chk("arch in", 32'h8, rd);
      tryOp(OP_RET, 2'd0, 1'b0, 32'h3, mk(DT_CODE_XO, 2'd3, 1'b0, 1'b1), 8'h00);
      apb(1'b0, ADDR_CUR_SS, 32'h0);
      chk("old ss", 32'h2b, rd);
    end
    g.descriptor_privilege_field = 2'd2;
    tryOp(OP_CALL, 2'd3, 1'b0, 32'h3, g, EXC_GP);
    apb(1'b0, ADDR_CUR_SS, 32'h0);
    chk("ss kept", 32'h2b, rd);
    tryOp(OP_CALL, 2'd0, 1'b0, 32'h3, g, EXC_GP);
    g.descriptor_privilege_field = 2'd3;
    g.tgtDpl = 2'd2;
    tryOp(OP_CALL, 2'd1, 1'b0, 32'h1, g, EXC_GP);
    for (int k = 0; k < 2; k++) begin
      g = mk(k ? DT_TRAP_GATE : DT_INT_GATE, 2'd3, 1'b0, 1'b1);
      g.fromIdt = 1'b1;
      g.wordCount = 5'd3;
      tryOp(OP_INT, 2'd3, 1'b0, 32'h3, g, 8'h00);
      chk("int pushes", 32'd4, {24'h0, st.pushCount});
      apb(1'b0, ADDR_ARCH, 32'h0);
      chk("arch int", k ? 32'h8 : 32'h0, rd);
    end
    for (int i = 0; i < 8; i++) begin
      x = 2'($urandom);
      y = 2'($urandom);
      tryOp(OP_ADJUST_PRIVILEGE_OP, 2'd0, 1'b0, {14'h0, y, 14'h1a5, x}, mk(DT_DATA_RO, 2'd0, 1'b0, 1'b1), 8'h00);
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk("adjusted", {16'h0, 14'h1a5, mx(x, y)}, rd);
      chk("zero flag", {31'h0, y > x}, {31'h0, st.zf});
    end
    for (int i = 0; i < 16; i++) begin
      x = 2'($urandom);
      y = 2'($urandom);
      z = 2'($urandom);
      g = mk(($urandom & 1) ? DT_DATA_RW : DT_DATA_RO, z, 1'b0, i[0]);
      tryOp(OP_LOAD_DATA, x, 1'b0, {30'h4, y}, g, dataExp(x, y, z, i[0]));
    end
    psel <= 1'b0;
    @(posedge core_clk);
    summarize();
  end
endmodule : testbench
`default_nettype wire
